// file: hw/fcct_defines.vh
// Operation
// - channel C/D role bit: 0 output compare, 1 input capture
// - compare pin action: 00 none, 01 low, 10 high, 11 toggle
// - capture edge: 00 rising, 01 falling, 1X both edges
// - bits 7 and 3 of the C/D io control register read as 1
// - 16-bit readable/writable up-counter, source from clock select, reset to 0000
// - channel A compare with clear bit set clears counter and sets flag A
// - wrap FFFF to 0000 sets overflow flag; interrupt if enabled
// - compare register equal to counter sets match flag; interrupt if enabled
// - capture edge loads counter into register, sets flag; interrupt if enabled
// - two buffer enables make C buffer A and D buffer B
// - buffered compare A copies C into A at each A match
// - buffered capture A moves old A into C, counter into A
// - general registers 16 bits, 16-bit access only, reset to FFFF
// - counter free-runs after reset, counts only while run bit is 1; here the run bit resets to 0, so the counter holds 0000 until it is set
// - fixed-level action on a pin already at that level changes nothing
// - PWM: A is period, B..D duty, all registers forced to compare
// - PWM level bit 1: high at A match, low at duty match; 0 reversed
// - PWM pins ignore the compare pin-action fields
// - PWM duty equal to period leaves the pin unchanged
// - PWM with D buffering B copies D into B at each B match
// - compare match acts only when the counter advances past the equal value
// - flag clears only by reading it as 1 then writing 0
`ifndef FCCT_DEFINES_VH
`define FCCT_DEFINES_VH
`define FCCT_OFS_MODE 8'h00
`define FCCT_OFS_CTRL 8'h04
`define FCCT_OFS_IE 8'h08
`define FCCT_OFS_STAT 8'h0C
`define FCCT_OFS_IOAB 8'h10
`define FCCT_OFS_IOCD 8'h14
`define FCCT_OFS_CNT 8'h18
`define FCCT_OFS_GRA 8'h1C
`define FCCT_OFS_GRB 8'h20
`define FCCT_OFS_GRC 8'h24
`define FCCT_OFS_GRD 8'h28
`define FCCT_MODE_RUN 0
`define FCCT_MODE_BUFA 1
`define FCCT_MODE_BUFB 2
`define FCCT_MODE_PWMB 3
`define FCCT_MODE_PWMC 4
`define FCCT_MODE_PWMD 5
`define FCCT_CTRL_LVLB 0
`define FCCT_CTRL_LVLC 1
`define FCCT_CTRL_LVLD 2
`define FCCT_CTRL_CKS_HI 6
`define FCCT_CTRL_CKS_LO 4
`define FCCT_CTRL_COUNTER_CLEAR_ON_MATCH_A 7
`define FCCT_IE_OVERFLOW_IRQ_ENABLE 7
`define FCCT_STAT_OVF 7
`define FCCT_IO_RSVD 8'h88
`define FCCT_CNT_RST 16'h0000
`define FCCT_CNT_MAX 16'hFFFF
`define FCCT_GR_RST 16'hFFFF
`define FCCT_RESP_OKAY 2'h0
`define FCCT_RESP_SLVERR 2'h2
`endif

// file: hw/fcct_timer.v
// Added by the designer: the register offsets and register access over AXI4-Lite.
`timescale 1ns/100ps
`include "fcct_defines.vh"
module fcct_timer (
  input wire mclk,
  input wire arst_n,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [3:0] timerPinIn,
  output wire [3:0] timerPinOut,
  output wire [3:0] timerPinOe,
  input wire extClkIn,
  output wire irqReq
);

  // bus slave state
  reg awHeld_ff;
  reg [7:0] awAddr_ff;
  reg wHeld_ff;
  reg [31:0] wData_ff;
  reg [3:0] wStrb_ff;
  reg bvalid_ff;
  reg [1:0] bresp_ff;
  reg rvalid_ff;
  reg [31:0] rdata_ff;
  reg [1:0] rresp_ff;

  // timer registers
  reg [5:0] mode_ff;
  reg [7:0] ctrl_ff;
  reg [3:0] matchIe_ff;
  reg ovfIe_ff;
  reg [3:0] flag_ff;
  reg ovf_ff;
  reg [4:0] arm_ff;
  reg [7:0] ioAb_ff;
  reg [7:0] ioCd_ff;
  reg [15:0] cnt_ff;
  reg [15:0] gr_ff [0:3];
  reg [3:0] pin_ff;
  reg [3:0] pinPrev_ff;
  reg extPrev_ff;
  reg [2:0] presc_ff;
  reg irq_ff;

  wire [3:0] matchEv;
  wire [3:0] capEv;
  wire [3:0] icRole;
  wire [3:0] nxtPin;
  wire [15:0] nxtGr [0:3];
  reg [31:0] nxtRdata;
  reg [1:0] nxtRresp;
  reg srcTick;
  integer k;

  // handshakes
  assign s_axi_awready = ~awHeld_ff & ~bvalid_ff;
  assign s_axi_wready = ~wHeld_ff & ~bvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = ~rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  wire wrFire = awHeld_ff & wHeld_ff & ~bvalid_ff;
  wire rdFire = s_axi_arvalid & ~rvalid_ff;
  // narrow writes to 16-bit registers would tear the value, so they are refused
  wire wr16Ok = (wStrb_ff[1:0] == 2'h3);
  wire wr8Ok = wStrb_ff[0];

  wire hitMode = (awAddr_ff == `FCCT_OFS_MODE);
  wire hitCtrl = (awAddr_ff == `FCCT_OFS_CTRL);
  wire hitIe = (awAddr_ff == `FCCT_OFS_IE);
  wire hitStat = (awAddr_ff == `FCCT_OFS_STAT);
  wire hitIoAb = (awAddr_ff == `FCCT_OFS_IOAB);
  wire hitIoCd = (awAddr_ff == `FCCT_OFS_IOCD);
  wire hitCnt = (awAddr_ff == `FCCT_OFS_CNT);
  wire [3:0] hitGr;
  wire hit8 = hitMode | hitCtrl | hitIe | hitStat | hitIoAb | hitIoCd;
  wire hit16 = hitCnt | (|hitGr);
  wire wrOk = (hit8 & wr8Ok) | (hit16 & wr16Ok);

  wire stWr = wrFire & hitStat & wr8Ok;
  wire cntWr = wrFire & hitCnt & wr16Ok;
  wire rdStat = rdFire & (s_axi_araddr == `FCCT_OFS_STAT);

  // mode decode
  wire runOn = mode_ff[`FCCT_MODE_RUN];
  wire [1:0] bufEn = {mode_ff[`FCCT_MODE_BUFB], mode_ff[`FCCT_MODE_BUFA]};
  wire [3:0] pwmSel = {mode_ff[`FCCT_MODE_PWMD], mode_ff[`FCCT_MODE_PWMC],
                       mode_ff[`FCCT_MODE_PWMB], 1'b0};
  wire pwmAny = |pwmSel;
  wire [3:0] pwmLvl = {ctrl_ff[`FCCT_CTRL_LVLD], ctrl_ff[`FCCT_CTRL_LVLC],
                       ctrl_ff[`FCCT_CTRL_LVLB], 1'b0};
  wire [2:0] clkSel = ctrl_ff[`FCCT_CTRL_CKS_HI:`FCCT_CTRL_CKS_LO];
  wire cclrOn = ctrl_ff[`FCCT_CTRL_COUNTER_CLEAR_ON_MATCH_A];

  // count source: mclk, mclk/2, /4, /8 or rising edge of the external clock
  always @* begin
    case (clkSel)
      3'h0: srcTick = 1'b1;
      3'h1: srcTick = presc_ff[0];
      3'h2: srcTick = &presc_ff[1:0];
      3'h3: srcTick = &presc_ff;
      default: srcTick = extClkIn & ~extPrev_ff;
    endcase
  end

  wire cntTick = runOn & srcTick;
  wire clrCnt = matchEv[0] & cclrOn;
  wire ovfEv = cntTick & (cnt_ff == `FCCT_CNT_MAX) & ~clrCnt & ~cntWr;

  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : gCh
      localparam integer P = i ^ 2;
      localparam integer GOF = `FCCT_OFS_GRA + 4 * i;
      wire [7:0] ioReg = (i < 2) ? ioAb_ff : ioCd_ff;
      wire [2:0] ioF = (i % 2 == 1) ? ioReg[6:4] : ioReg[2:0];
      wire [1:0] act = ioF[1:0];
      // a buffer register only shadows its partner; it neither compares nor captures
      wire isBuf = (i >= 2) & bufEn[i % 2];
      wire hasBuf = (i < 2) & bufEn[i % 2];
      wire rise = timerPinIn[i] & ~pinPrev_ff[i];
      wire fall = ~timerPinIn[i] & pinPrev_ff[i];
      reg edgeHit;
      wire grWr = wrFire & (awAddr_ff == GOF[7:0]) & wr16Ok;
      wire pin = pin_ff[i];
      reg ocNext;
      reg pwmNext;

      assign hitGr[i] = (awAddr_ff == GOF[7:0]);
      assign icRole[i] = ioF[2] & ~pwmAny;
      assign capEv[i] = icRole[i] & ~isBuf & edgeHit;
      // match fires on the tick that moves the counter off the equal value
      assign matchEv[i] = ~icRole[i] & ~isBuf & cntTick & (cnt_ff == gr_ff[i]);

      // hardware loads win over a software write landing in the same cycle
      assign nxtGr[i] = capEv[i] ? cnt_ff :
                        (hasBuf & matchEv[i]) ? gr_ff[P] :
                        (isBuf & capEv[P]) ? gr_ff[P] :
                        grWr ? wData_ff[15:0] : gr_ff[i];

      always @* begin
        ocNext = pin;
        if (matchEv[i]) begin
          case (act)
            2'h1: ocNext = 1'b0;
            2'h2: ocNext = 1'b1;
            2'h3: ocNext = ~pin;
            default: ocNext = pin;
          endcase
        end
      end

      always @* begin
        case (ioF[1:0])
          2'h0: edgeHit = rise;
          2'h1: edgeHit = fall;
          default: edgeHit = rise | fall;
        endcase
      end

      always @* begin
        pwmNext = pin;
        if (gr_ff[i] == gr_ff[0]) begin
          pwmNext = pin;
        end else if (matchEv[i]) begin
          pwmNext = ~pwmLvl[i];
        end else if (matchEv[0]) begin
          pwmNext = pwmLvl[i];
        end
      end
      assign nxtPin[i] = pwmSel[i] ? pwmNext : ocNext;
    end
  endgenerate

  assign timerPinOut = pin_ff;
  assign timerPinOe = ~icRole;
  assign irqReq = irq_ff;

  // read data mux
  always @* begin
    nxtRresp = `FCCT_RESP_OKAY;
    case (s_axi_araddr)
      `FCCT_OFS_MODE: nxtRdata = {26'h0000000, mode_ff};
      `FCCT_OFS_CTRL: nxtRdata = {24'h000000, ctrl_ff};
      `FCCT_OFS_IE: nxtRdata = {24'h000000, ovfIe_ff, 3'h0, matchIe_ff};
      `FCCT_OFS_STAT: nxtRdata = {24'h000000, ovf_ff, 3'h0, flag_ff};
      `FCCT_OFS_IOAB: nxtRdata = {24'h000000, ioAb_ff | `FCCT_IO_RSVD};
      `FCCT_OFS_IOCD: nxtRdata = {24'h000000, ioCd_ff | `FCCT_IO_RSVD};
      `FCCT_OFS_CNT: nxtRdata = {16'h0000, cnt_ff};
      `FCCT_OFS_GRA: nxtRdata = {16'h0000, gr_ff[0]};
      `FCCT_OFS_GRB: nxtRdata = {16'h0000, gr_ff[1]};
      `FCCT_OFS_GRC: nxtRdata = {16'h0000, gr_ff[2]};
      `FCCT_OFS_GRD: nxtRdata = {16'h0000, gr_ff[3]};
      default: begin
        nxtRdata = 32'h00000000;
        nxtRresp = `FCCT_RESP_SLVERR;
      end
    endcase
  end

  // bus channels
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      awHeld_ff <= 1'b0;
      awAddr_ff <= 8'h00;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        awHeld_ff <= 1'b1;
        awAddr_ff <= s_axi_awaddr;
      end else if (wrFire) begin
        awHeld_ff <= 1'b0;
      end
    end
  end

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wHeld_ff <= 1'b0;
      wData_ff <= 32'h00000000;
      wStrb_ff <= 4'h0;
    end else begin
      if (s_axi_wvalid & s_axi_wready) begin
        wHeld_ff <= 1'b1;
        wData_ff <= s_axi_wdata;
        wStrb_ff <= s_axi_wstrb;
      end else if (wrFire) begin
        wHeld_ff <= 1'b0;
      end
    end
  end

  // the response waits for both halves of the write
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= `FCCT_RESP_OKAY;
    end else begin
      if (wrFire) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= wrOk ? `FCCT_RESP_OKAY : `FCCT_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= `FCCT_RESP_OKAY;
    end else begin
      if (rdFire) begin
        rvalid_ff <= 1'b1;
        rdata_ff <= nxtRdata;
        rresp_ff <= nxtRresp;
      end else if (s_axi_rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  // control registers
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mode_ff <= 6'h00;
      ctrl_ff <= 8'h00;
      matchIe_ff <= 4'h0;
      ovfIe_ff <= 1'b0;
      ioAb_ff <= `FCCT_IO_RSVD;
      ioCd_ff <= `FCCT_IO_RSVD;
    end else if (wrFire & wr8Ok) begin
      if (hitMode) begin
        mode_ff <= wData_ff[5:0];
      end
      if (hitCtrl) begin
        ctrl_ff <= wData_ff[7:0];
      end
      if (hitIe) begin
        matchIe_ff <= wData_ff[3:0];
        ovfIe_ff <= wData_ff[`FCCT_IE_OVERFLOW_IRQ_ENABLE];
      end
      if (hitIoAb) begin
        ioAb_ff <= wData_ff[7:0] | `FCCT_IO_RSVD;
      end
      if (hitIoCd) begin
        ioCd_ff <= wData_ff[7:0] | `FCCT_IO_RSVD;
      end
    end
  end

  // a new event wins over a clear in the same cycle
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      flag_ff <= 4'h0;
      ovf_ff <= 1'b0;
      arm_ff <= 5'h00;
    end else begin
      flag_ff <= (matchEv | capEv) |
                 (flag_ff & ~({4{stWr}} & ~wData_ff[3:0] & arm_ff[3:0]));
      ovf_ff <= ovfEv |
                (ovf_ff & ~(stWr & ~wData_ff[`FCCT_STAT_OVF] & arm_ff[4]));
      // only bits seen as 1 by a status read may be cleared by the next write
      if (rdStat) begin
        arm_ff <= {ovf_ff, flag_ff};
      end else if (stWr) begin
        arm_ff <= 5'h00;
      end
    end
  end

  // clear from match A outranks a software write, which outranks a tick
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff <= `FCCT_CNT_RST;
      presc_ff <= 3'h0;
      extPrev_ff <= 1'b0;
    end else begin
      if (clrCnt) begin
        cnt_ff <= `FCCT_CNT_RST;
      end else if (cntWr) begin
        cnt_ff <= wData_ff[15:0];
      end else if (cntTick) begin
        cnt_ff <= cnt_ff + 16'h0001;
      end
      presc_ff <= presc_ff + 3'h1;
      extPrev_ff <= extClkIn;
    end
  end

  // capture, buffer and software loads are chosen per channel above
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      for (k = 0; k < 4; k = k + 1) begin
        gr_ff[k] <= `FCCT_GR_RST;
      end
    end else begin
      for (k = 0; k < 4; k = k + 1) begin
        gr_ff[k] <= nxtGr[k];
      end
    end
  end

  // pin inputs are taken as synchronous; an async source needs a synchroniser outside
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pin_ff <= 4'h0;
      pinPrev_ff <= 4'h0;
      irq_ff <= 1'b0;
    end else begin
      pin_ff <= nxtPin;
      pinPrev_ff <= timerPinIn;
      // request follows the enabled sticky flags, one cycle late
      irq_ff <= (|(flag_ff & matchIe_ff)) | (ovf_ff & ovfIe_ff);
    end
  end

endmodule

// file: verif/fcct_timer_asserts.sv
`timescale 1ns/100ps
module fcct_timer_chk (
  input wire mclk,
  input wire arst_n,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [3:0] timerPinOe
);
  reg [7:0] awA_ff;
  reg [3:0] wS_ff;
  reg [7:0] arA_ff;
  // the answer comes after address and strobe are gone, so keep them
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      awA_ff <= 8'h00;
      wS_ff <= 4'h0;
      arA_ff <= 8'h00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) awA_ff <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) wS_ff <= s_axi_wstrb;
      if (s_axi_arvalid && s_axi_arready) arA_ff <= s_axi_araddr;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_wr_answer;
    s_wr_both |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
  property p_wr_done;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready;
  endproperty
  a_wr_done: assert property (p_wr_done) else $error("write not closed");
  property p_rd_answer;
    s_rd_take |=> s_axi_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
  property p_rd_done;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready;
  endproperty
  a_rd_done: assert property (p_rd_done) else $error("read not closed");
  property p_io_rsvd;
    s_axi_rvalid && arA_ff == 8'h14 |-> s_axi_rdata[7] && s_axi_rdata[3];
  endproperty
  a_io_rsvd: assert property (p_io_rsvd) else $error("reserved bits low");
  property p_narrow;
    s_axi_bvalid && awA_ff >= 8'h18 && awA_ff <= 8'h28 && wS_ff[1:0] != 2'h3
      |-> s_axi_bresp == 2'h2;
  endproperty
  a_narrow: assert property (p_narrow) else $error("narrow write accepted");
  property p_unmapped;
    s_axi_rvalid && arA_ff > 8'h28 |-> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read answered");
  property p_oe_change;
    $changed(timerPinOe) |-> $rose(s_axi_bvalid);
  endproperty
  a_oe_change: assert property (p_oe_change) else $error("pin role moved alone");
endmodule
bind fcct_timer fcct_timer_chk i_chk (.mclk(mclk), .arst_n(arst_n),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .timerPinOe(timerPinOe));

// file: verif/fcct_pin_model.sv
`timescale 1ns/100ps
module fcct_pin_model (
  input wire [3:0] pinOut,
  input wire [3:0] pinOe,
  input wire [3:0] farLevel,
  output wire [3:0] pinLevel
);
  // a driven pin reads back its own level, a released one the far side
  assign pinLevel = (pinOe & pinOut) | (~pinOe & farLevel);
endmodule

// file: verif/testbench.sv
`timescale 1ns/100ps
module testbench;
  typedef struct packed {
    logic [7:0] a;
    logic [31:0] d;
    logic [3:0] s;
    logic [1:0] br;
    logic [31:0] q;
    logic [1:0] qr;
  } fcct_row_t;
  fcct_row_t rows [6] = '{
    '{8'h1C, 32'h1234, 4'hF, 2'h0, 32'h1234, 2'h0},
    '{8'h20, 32'hABCD, 4'h1, 2'h2, 32'hFFFF, 2'h0},
    '{8'h14, 32'h0, 4'hF, 2'h0, 32'h88, 2'h0},
    '{8'h14, 32'h77, 4'hF, 2'h0, 32'hFF, 2'h0},
    '{8'h18, 32'h100, 4'h3, 2'h0, 32'h100, 2'h0},
    '{8'h40, 32'h1, 4'hF, 2'h2, 32'h0, 2'h2}};
  logic mclk, arst_n, awValid, wValid, bReady, arValid, rReady, irqReq;
  logic awReady, wReady, bValid, arReady, rValid, ext;
  logic [7:0] awAddr, arAddr;
  logic [31:0] wData, rData, d;
  logic [3:0] wStrb, far, pinIn, pinOut, pinOe;
  logic [1:0] bResp, rResp, r;
  int bad_count, num_checks, i, m, n;
  fcct_timer i_dut (.mclk(mclk), .arst_n(arst_n), .s_axi_awaddr(awAddr),
    .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
    .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
    .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
    .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
    .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady), .timerPinIn(pinIn),
    .timerPinOut(pinOut), .timerPinOe(pinOe), .extClkIn(ext), .irqReq(irqReq));
  fcct_pin_model i_pins (.pinOut(pinOut), .pinOe(pinOe), .farLevel(far), .pinLevel(pinIn));
  always #4 mclk = ~mclk;
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic tmo;
    bad_count++;
    report_and_stop();
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // handshakes are judged at the falling edge, then released after the rising one
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s,
    output logic [1:0] o);
    logic ta, tw, tb;
    @(posedge mclk);
    {awAddr, wData, wStrb} <= {a, v, s};
    {awValid, wValid, bReady} <= 3'h7;
    n = 0;
    do begin
      @(negedge mclk);
      ta = awReady & awValid;
      tw = wReady & wValid;
      tb = bValid & bReady;
      o = bResp;
      @(posedge mclk);
      if (ta) awValid <= 1'b0;
      if (tw) wValid <= 1'b0;
      if (tb) bReady <= 1'b0;
      n++;
    end while (!tb && n < 50);
    if (!tb) tmo();
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] o);
    logic ta, tb;
    @(posedge mclk);
    arAddr <= a;
    {arValid, rReady} <= 2'h3;
    n = 0;
    do begin
      @(negedge mclk);
      ta = arReady & arValid;
      tb = rValid & rReady;
      {v, o} = {rData, rResp};
      @(posedge mclk);
      if (ta) arValid <= 1'b0;
      if (tb) rReady <= 1'b0;
      n++;
    end while (!tb && n < 50);
    if (!tb) tmo();
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] v);
    wr(a, v, 4'hF, r);
  endtask
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
    rd(a, d, r);
    chk(nm, e, d);
  endtask
  task automatic waitPin(input logic v);
    for (m = 0; m < 200 && pinOut[1] !== v; m++) @(negedge mclk);
    chk("pwm pin b", {31'h0, v}, {31'h0, pinOut[1]});
    if (pinOut[1] !== v) report_and_stop();
  endtask
  initial begin
    mclk = 1'b0;
    arst_n = 1'b0;
    {awValid, wValid, bReady, arValid, rReady} = 5'h0;
    {awAddr, arAddr, wData, wStrb, far} = 56'h0;
    ext = 1'b0;
    repeat (4) @(posedge mclk);
    arst_n <= 1'b1;
    for (i = 0; i < 6; i++) begin
      wr(rows[i].a, rows[i].d, rows[i].s, r);
      chk("bresp", {30'h0, rows[i].br}, {30'h0, r});
      rd(rows[i].a, d, r);
      chk("rdata", rows[i].q, d);
      chk("rresp", {30'h0, rows[i].qr}, {30'h0, r});
    end
    w(8'h1C, 32'h5);
    w(8'h04, 32'h80);
    w(8'h08, 32'h1);
    w(8'h10, 32'h2);
    w(8'h18, 32'h0);
    w(8'h00, 32'h1);
    for (n = 0; n < 60 && irqReq !== 1'b1; n++) @(negedge mclk);
    if (irqReq !== 1'b1) tmo();
    w(8'h00, 32'h0);
    chk("pin a", 32'h1, {31'h0, pinOut[0]});
    rd(8'h18, d, r);
    chk("count bound", 32'h1, {31'h0, d <= 32'h5});
    // a clear without a prior read of the set flag must not take
    w(8'h0C, 32'h0);
    rc("flag kept", 8'h0C, 32'h1);
    w(8'h0C, 32'h0);
    rc("flag clear", 8'h0C, 32'h0);
    chk("irq", 32'h0, {31'h0, irqReq});
    for (m = 0; m < 4; m++) begin
      w(8'h14, 32'h4 | m);
      w(8'h18, 32'h10 + m);
      far[2] <= 1'b1;
      repeat (3) @(posedge mclk);
      w(8'h18, 32'h20 + m);
      far[2] <= 1'b0;
      repeat (3) @(posedge mclk);
      rc("capture c", 8'h24, m == 0 ? 32'h10 : 32'h20 + m);
    end
    w(8'h10, 32'h4);
    w(8'h00, 32'h2);
    w(8'h18, 32'h33);
    far[0] <= 1'b1;
    repeat (3) @(posedge mclk);
    rc("buffer a", 8'h1C, 32'h33);
    rc("buffer c", 8'h24, 32'h5);
    w(8'h00, 32'h8);
    chk("pwm roles", 32'hF, {28'h0, pinOe});
    w(8'h18, 32'hFFFE);
    w(8'h00, 32'h1);
    rd(8'h0C, d, r);
    chk("overflow", 32'h1, {31'h0, d[7]});
    w(8'h00, 32'h0);
    w(8'h04, 32'h40);
    w(8'h18, 32'h0);
    w(8'h00, 32'h1);
    for (m = 0; m < 3; m++) begin
      ext <= 1'b1;
      repeat (2) @(posedge mclk);
      ext <= 1'b0;
      repeat (2) @(posedge mclk);
    end
    rc("ext count", 8'h18, 32'h3);
    w(8'h00, 32'h0);
    w(8'h04, 32'h81);
    w(8'h1C, 32'h40);
    w(8'h20, 32'h20);
    w(8'h10, 32'h0);
    w(8'h18, 32'h0);
    w(8'h00, 32'h9);
    waitPin(1'b1);
    rd(8'h18, d, r);
    chk("pwm rise", 32'h1, {31'h0, d < 32'h20});
    waitPin(1'b0);
    rd(8'h18, d, r);
    chk("pwm fall", 32'h1, {31'h0, d >= 32'h20 && d < 32'h40});
    arst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    rc("gra reset", 8'h1C, 32'hFFFF);
    rc("io reset", 8'h14, 32'h88);
    rc("count idle", 8'h18, 32'h0);
    report_and_stop();
  end
endmodule
